// File: hw/ectc_top.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ectc_regs.svh"
// How it works
// - Readout-begin origin clears the counter each time readout begins.
// - Readout-finish origin clears the counter each time readout finishes.
// - Frame-trigger origin clears the counter on each frame-begin trigger.
// - Accepted-trigger origin clears the counter on each accepted frame trigger.
// - Rejected-trigger origin clears the counter on each rejected frame trigger.
// - Multi-frame origin clears the counter when a frame burst completes.
// - Pin one or pin two origin clears on that pin's chosen transition.
// - Timer-done origin clears the counter each time the timer completes.
// - Count-end origin clears the counter on its own terminal event.
// - Pin clearing uses rising, falling or either edge per polarity setting.
// - Terminal event fires when count reaches the programmed terminal value.
// - Software can read the present count at any time.
// - Every clear captures the count just before it into a snapshot.
// - Clear command zeroes the counter and counting resumes at once.
// - Count source Off suspends counting.
// - Timer selector exists; timer one is its only choice.
// - Timer is Off or Active; configuration accepted only while Off.
// - Timer reports unused state when its start origin is off.
// - Enabled timer reports waiting until its start trigger arrives.
// - Timer reports counting while running towards its duration.
// - Timer reports done once elapsed count reaches its duration.
// - After a triggered clear the counter waits for its start origin.
// - Timer duration is programmed and counted in microseconds.
// - Internal-clock counting advances once per microsecond tick.
module ectc_top (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rstn_in,
	// Register port
	input  wire logic [`ECTC_ADDR_W-1:0]    addr_in,
	input  wire logic [31:0]                wdata_in,
	input  wire logic                       wr_in,
	input  wire logic                       rd_in,
	output logic      [31:0]                rdata_out,
	// Device events, asynchronous levels toggled or pulsed
	input  wire logic                       sensor_readout_begin_in,
	input  wire logic                       sensor_readout_finish_in,
	input  wire logic                       frame_begin_trigger_in,
	input  wire logic                       accepted_frame_trigger_in,
	input  wire logic                       rejected_frame_trigger_in,
	input  wire logic                       multi_frame_done_in,
	input  wire logic                       input_pin_one_in,
	input  wire logic                       input_pin_two_in,
	// Event outputs
	output logic                            first_count_terminal_event_out,
	output logic                            first_tmr_done_event_out,
	output ectc_pkg::ectc_tstate_t          tmr_state_report_out
);
	import ectc_pkg::*;

	localparam int NEV = 8;
	localparam logic [5:0] TICK_MAX = 6'(`ECTC_TICK_CYCLES - 1);

	// ****************************************
	// Input synchronisers and edge detection
	// ****************************************
	logic [NEV-1:0] ev_raw;
	logic [NEV-1:0] sync_a;
	logic [NEV-1:0] sync_b;
	logic [NEV-1:0] sync_c;
	logic [NEV-1:0] rise;
	logic [NEV-1:0] fall;
	assign ev_raw = {input_pin_two_in, input_pin_one_in, multi_frame_done_in,
		rejected_frame_trigger_in, accepted_frame_trigger_in, frame_begin_trigger_in,
		sensor_readout_finish_in, sensor_readout_begin_in};

	// Two-stage synchroniser plus history stage
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end else begin
			sync_a <= ev_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	// Warm-up count, masks the false edge of a pin held high through reset
	logic [1:0] warm;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			warm <= 2'h0;
		end else if (warm != 2'h3) begin
			warm <= warm + 2'h1;
		end
	end
	// One-cycle pulses from synchronised levels, none until history is real
	assign rise = (warm == 2'h3) ? (sync_b & ~sync_c) : '0;
	assign fall = (warm == 2'h3) ? (~sync_b & sync_c) : '0;

	// ****************************************
	// Configuration registers
	// ****************************************
	ectc_clr_t    clr_origin;
	ectc_edge_t   clr_edge;
	logic [31:0]  terminal;
	ectc_src_t    count_src;
	ectc_start_t  count_start;
	logic         tmr_pick;
	logic         tmr_active;
	ectc_start_t  tmr_start;
	logic [31:0]  tmr_length_us;
	logic         clear_cmd;
	logic         tmr_cfg_ok;

	assign tmr_cfg_ok = !tmr_active;

	// Software writes to configuration
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clr_origin    <= CLR_CMD_ONLY;
			clr_edge      <= EDGE_UP;
			terminal      <= `ECTC_TERMINAL_RST;
			count_src     <= SRC_OFF;
			count_start   <= START_OFF;
			tmr_pick      <= 1'b0;
			tmr_active    <= 1'b0;
			tmr_start     <= START_OFF;
			tmr_length_us <= `ECTC_TMR_LENGTH_RST;
		end else if (wr_in) begin
			unique case (addr_in)
				`ECTC_OFF_CLR_ORIGIN: clr_origin  <= ectc_clr_t'(wdata_in[3:0]);
				`ECTC_OFF_CLR_EDGE:   clr_edge    <= ectc_edge_t'(wdata_in[1:0]);
				`ECTC_OFF_TERMINAL:   terminal    <= wdata_in;
				`ECTC_OFF_COUNT_SRC:  count_src   <= ectc_src_t'(wdata_in[1:0]);
				`ECTC_OFF_START_SRC:  count_start <= ectc_start_t'(wdata_in[1:0]);
				`ECTC_OFF_TMR_PICK:   tmr_pick    <= 1'b0;
				`ECTC_OFF_TMR_RUN:    tmr_active  <= wdata_in[0];
				`ECTC_OFF_TMR_START: begin
					if (tmr_cfg_ok) begin
						tmr_start <= ectc_start_t'(wdata_in[1:0]);
					end
				end
				`ECTC_OFF_TMR_LENGTH: begin
					if (tmr_cfg_ok) begin
						tmr_length_us <= wdata_in;
					end
				end
				default: ;
			endcase
		end
	end

	// Clear command pulse, write any value
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clear_cmd <= 1'b0;
		end else begin
			clear_cmd <= wr_in && (addr_in == `ECTC_OFF_CLEAR_CMD);
		end
	end

	// ****************************************
	// Microsecond tick divider
	// ****************************************
	logic [5:0] div;
	logic       tick;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div  <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (div == TICK_MAX);
			div  <= (div == TICK_MAX) ? 6'h00 : div + 6'h01;
		end
	end

	// ****************************************
	// Event counter
	// ****************************************
	logic [31:0] count;
	logic [31:0] snapshot;
	logic        running;
	logic        count_end;
	logic        tmr_done;
	logic        pin_edge;
	logic        trig_clear;
	logic        count_step;
	logic        count_go;
	logic        at_terminal;

	// Pin edge per polarity for the selected pin
	always_comb begin
		logic r;
		logic f;
		r = (clr_origin == CLR_PIN_TWO) ? rise[7] : rise[6];
		f = (clr_origin == CLR_PIN_TWO) ? fall[7] : fall[6];
		unique case (clr_edge)
			EDGE_UP:     pin_edge = r;
			EDGE_DOWN:   pin_edge = f;
			EDGE_EITHER: pin_edge = r | f;
			default:     pin_edge = 1'b0;
		endcase
	end

	// Triggered clear decode
	always_comb begin
		unique case (clr_origin)
			CLR_READOUT_BEGIN:  trig_clear = rise[0];
			CLR_READOUT_FINISH: trig_clear = rise[1];
			CLR_FRAME_BEGIN:    trig_clear = rise[2];
			CLR_ACCEPTED:       trig_clear = rise[3];
			CLR_REJECTED:       trig_clear = rise[4];
			CLR_MULTI_FRAME:    trig_clear = rise[5];
			CLR_PIN_ONE,
			CLR_PIN_TWO:        trig_clear = pin_edge;
			CLR_TMR_DONE:       trig_clear = tmr_done;
			CLR_COUNT_END:      trig_clear = count_end;
			default:            trig_clear = 1'b0;
		endcase
	end

	// Count increment source
	always_comb begin
		unique case (count_src)
			SRC_OFF:     count_step = 1'b0;
			SRC_TICK:    count_step = tick;
			SRC_PIN_ONE: count_step = rise[6];
			SRC_FRAME:   count_step = rise[2];
		endcase
	end

	// Counter start event
	always_comb begin
		unique case (count_start)
			START_OFF:       count_go = 1'b0;
			START_FRAME:     count_go = rise[2];
			START_PIN_ONE:   count_go = rise[6];
			START_COUNT_END: count_go = count_end;
		endcase
	end

	assign at_terminal = running && count_step && (count + 32'h1 >= terminal);

	// Count, run flag and snapshot
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count    <= '0;
			snapshot <= '0;
			running  <= 1'b0;
		end else if (clear_cmd) begin
			snapshot <= count;
			count    <= '0;
			running  <= 1'b1;
		end else if (trig_clear) begin
			snapshot <= count;
			count    <= '0;
			running  <= count_go;
		end else begin
			if (count_go) begin
				running <= 1'b1;
			end
			if (running && count_step) begin
				count <= count + 32'h1;
			end
		end
	end

	// Terminal event pulse
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_end <= 1'b0;
		end else begin
			count_end <= at_terminal && !clear_cmd && !trig_clear;
		end
	end
	assign first_count_terminal_event_out = count_end;

	// ****************************************
	// Timer
	// ****************************************
	ectc_tstate_t tstate;
	logic [31:0]  tmr_value;
	logic         tmr_go;

	// Timer start event
	always_comb begin
		unique case (tmr_start)
			START_OFF:       tmr_go = 1'b0;
			START_FRAME:     tmr_go = rise[2];
			START_PIN_ONE:   tmr_go = rise[6];
			START_COUNT_END: tmr_go = count_end;
		endcase
	end

	// Timer state machine, counts microsecond ticks
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tstate    <= TMR_STATE_UNUSED;
			tmr_value <= '0;
			tmr_done  <= 1'b0;
		end else begin
			tmr_done <= 1'b0;
			if (!tmr_active || tmr_start == START_OFF) begin
				tstate    <= TMR_STATE_UNUSED;
				tmr_value <= '0;
			end else begin
				unique case (tstate)
					TMR_STATE_UNUSED: tstate <= TMR_STATE_WAIT;
					TMR_STATE_WAIT, TMR_STATE_DONE: begin
						if (tmr_go) begin
							tstate    <= TMR_STATE_COUNTING;
							tmr_value <= '0;
						end
					end
					TMR_STATE_COUNTING: begin
						if (tick) begin
							tmr_value <= tmr_value + 32'h1;
							if (tmr_value + 32'h1 >= tmr_length_us) begin
								tstate   <= TMR_STATE_DONE;
								tmr_done <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end
	assign first_tmr_done_event_out = tmr_done;
	assign tmr_state_report_out = tstate;

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			unique case (addr_in)
				`ECTC_OFF_CLR_ORIGIN: rdata_out <= {28'h0, clr_origin};
				`ECTC_OFF_CLR_EDGE:   rdata_out <= {30'h0, clr_edge};
				`ECTC_OFF_TERMINAL:   rdata_out <= terminal;
				`ECTC_OFF_READBACK:   rdata_out <= count;
				`ECTC_OFF_SNAPSHOT:   rdata_out <= snapshot;
				`ECTC_OFF_COUNT_SRC:  rdata_out <= {30'h0, count_src};
				`ECTC_OFF_START_SRC:  rdata_out <= {30'h0, count_start};
				`ECTC_OFF_TMR_PICK:   rdata_out <= {31'h0, tmr_pick};
				`ECTC_OFF_TMR_RUN:    rdata_out <= {31'h0, tmr_active};
				`ECTC_OFF_TMR_START:  rdata_out <= {30'h0, tmr_start};
				`ECTC_OFF_TMR_LENGTH: rdata_out <= tmr_length_us;
				`ECTC_OFF_TMR_STATE:  rdata_out <= {30'h0, tstate};
				`ECTC_OFF_TMR_VALUE:  rdata_out <= tmr_value;
				default:              rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_cmd_clear;
		clear_cmd;
	endsequence
	a_cmd_zeroes: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_cmd_clear |=> (count == 32'h0) && running)
		else $error("clear command did not zero and run");
	a_snap_take: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(clear_cmd || trig_clear) |=> snapshot == $past(count))
		else $error("snapshot missed count");
	a_src_off_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(count_src == SRC_OFF && !clear_cmd && !trig_clear) |=> $stable(count))
		else $error("counter moved with source off");
	a_trig_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(trig_clear && !clear_cmd && !count_go) |=> !running)
		else $error("counter ran after triggered clear");
	a_end_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
		count_end |-> $past(count) + 32'h1 >= terminal)
		else $error("terminal event early");
	a_tmr_unused: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(tmr_start == START_OFF) |=> tstate == TMR_STATE_UNUSED)
		else $error("timer not unused");
	a_tmr_lock: assert property (@(posedge clk_in) disable iff (!rstn_in)
		tmr_active |=> $stable(tmr_length_us) && $stable(tmr_start))
		else $error("timer config changed while active");
	a_tmr_done: assert property (@(posedge clk_in) disable iff (!rstn_in)
		tmr_done |-> tstate == TMR_STATE_DONE && tmr_value >= tmr_length_us)
		else $error("timer done wrong");
endmodule : ectc_top

// File: hw/ectc_regs.svh
`ifndef ECTC_REGS_SVH
`define ECTC_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define ECTC_ADDR_W          8
`define ECTC_OFF_CLR_ORIGIN  8'h00
`define ECTC_OFF_CLR_EDGE    8'h04
`define ECTC_OFF_TERMINAL    8'h08
`define ECTC_OFF_READBACK    8'h0c
`define ECTC_OFF_SNAPSHOT    8'h10
`define ECTC_OFF_CLEAR_CMD   8'h14
`define ECTC_OFF_COUNT_SRC   8'h18
`define ECTC_OFF_START_SRC   8'h1c
`define ECTC_OFF_TMR_PICK    8'h20
`define ECTC_OFF_TMR_RUN     8'h24
`define ECTC_OFF_TMR_START   8'h28
`define ECTC_OFF_TMR_LENGTH  8'h2c
`define ECTC_OFF_TMR_STATE   8'h30
`define ECTC_OFF_TMR_VALUE   8'h34
// ****************************************
// Reset values and timing
// ****************************************
`define ECTC_TERMINAL_RST    32'h0000ffff
`define ECTC_TMR_LENGTH_RST  32'h000003e8
`define ECTC_CLK_MHZ         50
`define ECTC_TICK_US         1
`define ECTC_TICK_CYCLES     (`ECTC_CLK_MHZ * `ECTC_TICK_US)
`endif

// File: hw/ectc_pkg.sv
package ectc_pkg;
	// Counter clear origin selection
	typedef enum logic [3:0] {
		CLR_CMD_ONLY, CLR_READOUT_BEGIN, CLR_READOUT_FINISH, CLR_FRAME_BEGIN,
		CLR_ACCEPTED, CLR_REJECTED, CLR_MULTI_FRAME, CLR_PIN_ONE, CLR_PIN_TWO,
		CLR_TMR_DONE, CLR_COUNT_END
	} ectc_clr_t;
	// Line edge choice
	typedef enum logic [1:0] {EDGE_UP, EDGE_DOWN, EDGE_EITHER} ectc_edge_t;
	// Count source: off, internal microsecond tick, or counted event
	typedef enum logic [1:0] {SRC_OFF, SRC_TICK, SRC_PIN_ONE, SRC_FRAME} ectc_src_t;
	// Start origin for counter and timer
	typedef enum logic [1:0] {
		START_OFF, START_FRAME, START_PIN_ONE, START_COUNT_END
	} ectc_start_t;
	// Timer state report codes
	typedef enum logic [1:0] {
		TMR_STATE_UNUSED, TMR_STATE_WAIT, TMR_STATE_COUNTING, TMR_STATE_DONE
	} ectc_tstate_t;
endpackage : ectc_pkg

// File: bench/tb_top.sv
`timescale 1ns/10ps
`include "ectc_regs.svh"
module tb_top;
	import ectc_pkg::*;
	// ****************
	// Signals and design
	// ****************
	typedef struct {
		logic [3:0] org;
		logic [1:0] src;
		int         idx;
		logic       init;
		int         ntog;
		logic [1:0] edg;
		logic       hit;
	} ectc_tbrow_t;
	logic         clk_in   = 1'b0;
	logic         rstn_in  = 1'b0;
	logic [7:0]   addr_in  = 8'h00;
	logic [31:0]  wdata_in = 32'h0;
	logic         wr_in    = 1'b0;
	logic         rd_in    = 1'b0;
	logic [7:0]   ev       = 8'h00;
	logic [31:0]  rdata_out;
	logic         term_ev;
	logic         done_ev;
	ectc_tstate_t st;
	logic [31:0]  v;
	int           errors   = 0;
	int           n_checks = 0;
	int           n_term   = 0;
	int           n_done   = 0;
	int           k;
	int           ci;
	ectc_tbrow_t  rows [12];
	// Free-running clock
	always #10 clk_in = ~clk_in;
	ectc_top u_ectc_top (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.sensor_readout_begin_in(ev[0]), .sensor_readout_finish_in(ev[1]),
		.frame_begin_trigger_in(ev[2]), .accepted_frame_trigger_in(ev[3]),
		.rejected_frame_trigger_in(ev[4]), .multi_frame_done_in(ev[5]),
		.input_pin_one_in(ev[6]), .input_pin_two_in(ev[7]),
		.first_count_terminal_event_out(term_ev), .first_tmr_done_event_out(done_ev),
		.tmr_state_report_out(st));
	// Event pulse tallies
	always @(posedge clk_in) begin
		if (term_ev === 1'b1)
			n_term++;
		if (done_ev === 1'b1)
			n_done++;
	end
	// ****************
	// Tasks
	// ****************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1 d = rdata_out;
	endtask : rd
	// Flip one event line, then let the synchroniser settle
	task tog(input int i);
		@(posedge clk_in);
		ev[i] <= ~ev[i];
		cyc(6);
	endtask : tog
	task pulse(input int i);
		tog(i);
		tog(i);
	endtask : pulse
	task wait_st(input ectc_tstate_t s, input int bound, output int n);
		n = 0;
		while (st !== s && n < bound) begin
			@(posedge clk_in);
			#1 n++;
		end
		if (n >= bound) begin
			errors++;
			report_and_stop();
		end
	endtask : wait_st
	// ****************
	// Main sequence
	// ****************
	initial begin
		rows = '{
			'{4'h1, 2'h3, 0, 1'b0, 2, 2'h0, 1'b1},
			'{4'h2, 2'h3, 1, 1'b0, 2, 2'h0, 1'b1},
			'{4'h3, 2'h2, 2, 1'b0, 2, 2'h0, 1'b1},
			'{4'h4, 2'h3, 3, 1'b0, 2, 2'h0, 1'b1},
			'{4'h5, 2'h3, 4, 1'b0, 2, 2'h0, 1'b1},
			'{4'h6, 2'h3, 5, 1'b0, 2, 2'h0, 1'b1},
			'{4'h7, 2'h3, 6, 1'b0, 1, 2'h0, 1'b1},
			'{4'h7, 2'h3, 6, 1'b1, 1, 2'h0, 1'b0},
			'{4'h7, 2'h3, 6, 1'b1, 1, 2'h1, 1'b1},
			'{4'h8, 2'h3, 7, 1'b0, 1, 2'h1, 1'b0},
			'{4'h8, 2'h3, 7, 1'b1, 1, 2'h2, 1'b1},
			'{4'h8, 2'h3, 7, 1'b0, 1, 2'h2, 1'b1}};
		cyc(4);
		rstn_in <= 1'b1;
		#1 chk({rdata_out[27:0], st, term_ev, done_ev}, 32'h0);
		rd(`ECTC_OFF_TERMINAL, v);
		chk(v, `ECTC_TERMINAL_RST);
		rd(`ECTC_OFF_TMR_LENGTH, v);
		chk(v, `ECTC_TMR_LENGTH_RST);
		rd(8'hfc, v);
		chk(v, 32'h0);
		// Clear origins 1 to 6, one row each; pin origins 7 and 8 three rows each
		for (int r = 0; r < 12; r++) begin
			wr(`ECTC_OFF_CLR_ORIGIN, 32'h0);
			@(posedge clk_in);
			ev <= 8'(rows[r].init) << rows[r].idx;
			cyc(6);
			wr(`ECTC_OFF_CLR_EDGE, {30'h0, rows[r].edg});
			wr(`ECTC_OFF_COUNT_SRC, {30'h0, rows[r].src});
			wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
			ci = (rows[r].src == 2'h2) ? 6 : 2;
			repeat (3) pulse(ci);
			rd(`ECTC_OFF_READBACK, v);
			chk(v, 32'h3);
			wr(`ECTC_OFF_CLR_ORIGIN, {28'h0, rows[r].org});
			repeat (rows[r].ntog) tog(rows[r].idx);
			pulse(ci);
			rd(`ECTC_OFF_READBACK, v);
			chk(v, rows[r].hit ? 32'h0 : 32'h4);
			if (rows[r].hit) begin
				rd(`ECTC_OFF_SNAPSHOT, v);
				chk(v, 32'h3);
			end
		end
		// Command clear, suspend with source off
		wr(`ECTC_OFF_CLR_ORIGIN, 32'h0);
		wr(`ECTC_OFF_COUNT_SRC, 32'h3);
		wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
		repeat (2) pulse(2);
		wr(`ECTC_OFF_COUNT_SRC, 32'h0);
		repeat (2) pulse(2);
		rd(`ECTC_OFF_READBACK, v);
		chk(v, 32'h2);
		wr(`ECTC_OFF_COUNT_SRC, 32'h3);
		wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
		cyc(2);
		pulse(2);
		rd(`ECTC_OFF_READBACK, v);
		chk(v, 32'h1);
		rd(`ECTC_OFF_SNAPSHOT, v);
		chk(v, 32'h2);
		// Microsecond tick counting
		wr(`ECTC_OFF_COUNT_SRC, 32'h1);
		wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
		cyc(500);
		rd(`ECTC_OFF_READBACK, v);
		chk({31'h0, v >= 9 && v <= 11}, 32'h1);
		// Terminal count with self clear
		wr(`ECTC_OFF_TERMINAL, 32'h4);
		wr(`ECTC_OFF_CLR_ORIGIN, 32'ha);
		wr(`ECTC_OFF_COUNT_SRC, 32'h3);
		wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
		cyc(2);
		n_term = 0;
		repeat (3) pulse(2);
		chk(n_term, 32'h0);
		pulse(2);
		chk(n_term, 32'h1);
		rd(`ECTC_OFF_READBACK, v);
		chk(v, 32'h0);
		// Start origin restarts a counter stopped by a triggered clear
		wr(`ECTC_OFF_START_SRC, 32'h1);
		pulse(2);
		pulse(2);
		rd(`ECTC_OFF_READBACK, v);
		chk(v, 32'h1);
		rd(`ECTC_OFF_SNAPSHOT, v);
		chk(v, 32'h4);
		// Timer states and lock
		wr(`ECTC_OFF_TERMINAL, 32'hffff);
		wr(`ECTC_OFF_CLR_ORIGIN, 32'h9);
		wr(`ECTC_OFF_CLEAR_CMD, 32'h1);
		repeat (2) pulse(2);
		wr(`ECTC_OFF_TMR_LENGTH, 32'h3);
		wr(`ECTC_OFF_TMR_START, 32'h1);
		wr(`ECTC_OFF_TMR_RUN, 32'h1);
		wr(`ECTC_OFF_TMR_LENGTH, 32'h9);
		rd(`ECTC_OFF_TMR_LENGTH, v);
		chk(v, 32'h3);
		rd(`ECTC_OFF_TMR_PICK, v);
		chk(v, 32'h0);
		chk({30'h0, st}, 32'h1);
		n_done = 0;
		tog(2);
		wait_st(TMR_STATE_COUNTING, 20, k);
		wait_st(TMR_STATE_DONE, 400, k);
		chk({31'h0, k >= 2 * `ECTC_TICK_CYCLES - 4 && k <= 3 * `ECTC_TICK_CYCLES}, 32'h1);
		tog(2);
		chk(n_done, 32'h1);
		rd(`ECTC_OFF_SNAPSHOT, v);
		chk(v, 32'h3);
		wr(`ECTC_OFF_TMR_RUN, 32'h0);
		wr(`ECTC_OFF_TMR_START, 32'h0);
		wr(`ECTC_OFF_TMR_RUN, 32'h1);
		cyc(2);
		chk({30'h0, st}, 32'h0);
		// Reset in mid-run
		@(posedge clk_in);
		rstn_in <= 1'b0;
		cyc(2);
		chk({30'h0, st}, 32'h0);
		rstn_in <= 1'b1;
		rd(`ECTC_OFF_TMR_LENGTH, v);
		chk(v, `ECTC_TMR_LENGTH_RST);
		report_and_stop();
	end
endmodule : tb_top
